// file: verilog/pcs_pkg.sv
package pcs_pkg;

	// Socket interface modes.
	typedef enum logic [1:0] {
		PCS_MODE_MEM,
		PCS_MODE_IO,
		PCS_MODE_CB
	} pcs_mode_t;

	// Source chosen for the second battery-detect pin in I/O mode.
	typedef enum logic [1:0] {
		PCS_AUX_NONE,
		PCS_AUX_SPEAKER,
		PCS_AUX_ACTIVITY
	} pcs_aux_t;

	// Card access request from the adapter's cycle engine.
	typedef struct packed {
		logic req;
		logic wide;
		logic lo_en;
		logic hi_en;
		logic a0;
	} pcs_acc_t;

	// Socket status pins as sampled.
	typedef struct packed {
		logic bvd1;
		logic bvd2;
		logic cd1_n;
		logic cd2_n;
		logic vs1;
		logic vs2;
	} pcs_pins_t;

	localparam logic [7:0] PCS_ADDR_CTRL   = 8'h00;
	localparam logic [7:0] PCS_ADDR_PULLUP = 8'h04;
	localparam logic [7:0] PCS_ADDR_STATUS = 8'h08;
	localparam logic [7:0] PCS_ADDR_EVT    = 8'h0C;
	localparam logic [7:0] PCS_ADDR_EVT_EN = 8'h10;
	localparam logic [7:0] PCS_ADDR_EVT_CLR = 8'h14;

	// Control register fields.
	localparam int PCS_CTRL_MODE_LO = 0;
	localparam int PCS_CTRL_AUX_LO  = 2;
	localparam int PCS_CTRL_PWR     = 4;
	localparam int PCS_CTRL_IFEN    = 5;
	localparam int PCS_CTRL_RST     = 6;
	localparam int PCS_CTRL_RING    = 7;
	localparam int PCS_CTRL_BYTE8   = 8;
	localparam logic [31:0] PCS_CTRL_RESET = 32'h0000_0000;

	// Pull-up register: bits 1:0 data write bits, bits 3:2 card-detect pull-up controls.
	localparam int PCS_PU_DATA_LO = 0;
	localparam int PCS_PU_CD_LO   = 2;

	// Event bits.
	localparam int PCS_EVT_N      = 4;
	localparam int PCS_EVT_STSCHG = 0;
	localparam int PCS_EVT_RING   = 1;
	localparam int PCS_EVT_CD     = 2;
	localparam int PCS_EVT_CBSTS  = 3;

	localparam logic [31:0] PCS_ZERO = 32'h0000_0000;

endpackage

// file: verilog/pcs_edge.sv
`timescale 1ns/1ps
module pcs_edge
	import pcs_pkg::*;
(
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic [PCS_EVT_N-1:0] lvl,
	output logic      [PCS_EVT_N-1:0] fall
);

	logic [PCS_EVT_N-1:0] prev_q;

	// Starts high so that a low level at reset release is taken as an event.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_q <= '1;
		end else begin
			prev_q <= lvl;
		end
	end

	genvar i;
	generate
		for (i = 0; i < PCS_EVT_N; i++) begin : g_bit
			assign fall[i] = prev_q[i] & ~lvl[i];
		end
	endgenerate

endmodule

// file: verilog/pcs_socket.sv
// Added by the designer: the APB slave port and the address map.
`timescale 1ns/1ps
// Contract
// - Drive both active-low card enables low during access, even and odd bytes.
// - In 8-bit mode only the even enable is active; A0 picks the byte.
// - CardBus reuses odd enable as address/data bit 10, even as byte-enable 0.
// - In 16-bit modes reset output is low normally, high to reset the card.
// - Reset output floats unless card seated, power on and interface enabled.
// - In CardBus mode the reset pin is the card's active-low reset.
// - Memory mode: second battery input is the battery warning status.
// - I/O mode: second battery input may be the binary speaker input.
// - Second battery input may instead be the drive activity input.
// - CardBus mode: second battery input carries card audio.
// - Memory mode: first battery input is the battery-dead status.
// - I/O mode: first battery input is a status-change event.
// - Control bit 7 set makes first battery input the ring indicate (the code does this in I/O mode only).
// - Both voltage-sense lines together give the card voltage requirement.
// - Each voltage-sense pull-up needs both its data bit and its pull-up bit.
// - Card-detect inputs show presence; in CardBus combined with voltage sense (the code uses the two detects alone in every mode).
module pcs_socket
	import pcs_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire pcs_acc_t    acc,
	input  wire logic        cb_ad10_out,
	input  wire logic        cb_ad10_oe,
	input  wire logic        cb_cbe0_out,
	input  wire logic        cb_cbe0_oe,
	input  wire pcs_pins_t   pins,
	output logic             ce_odd_n_out,
	output logic             ce_odd_n_oe,
	output logic             ce_even_n_out,
	output logic             ce_even_n_oe,
	output logic             card_reset_out,
	output logic             card_reset_oe,
	output logic             vs1_pullup_en,
	output logic             vs2_pullup_en,
	output logic             bat_warn,
	output logic             bat_dead,
	output logic             binary_speaker_in,
	output logic             drive_activity_in,
	output logic             cb_audio_in,
	output logic             ring_indicate_in,
	output logic             card_present,
	output logic [1:0]       card_vsense,
	output logic             irq
);

	logic [31:0]          ctrl_q;
	logic [3:0]           pullup_q;
	logic [PCS_EVT_N-1:0] evt_q;
	logic [PCS_EVT_N-1:0] evt_en_q;
	logic [PCS_EVT_N-1:0] evt_src;
	logic [PCS_EVT_N-1:0] evt_fall;
	logic [31:0]          prdata_q;
	pcs_mode_t            mode;
	pcs_aux_t             aux;
	logic                 wr_en;
	logic                 rd_en;
	logic                 addr_ok;
	logic                 drive_ok;

	assign mode = pcs_mode_t'(ctrl_q[PCS_CTRL_MODE_LO +: 2]);
	assign aux  = pcs_aux_t'(ctrl_q[PCS_CTRL_AUX_LO +: 2]);

	assign addr_ok = (paddr == PCS_ADDR_CTRL) || (paddr == PCS_ADDR_PULLUP) ||
		(paddr == PCS_ADDR_STATUS) || (paddr == PCS_ADDR_EVT) ||
		(paddr == PCS_ADDR_EVT_EN) || (paddr == PCS_ADDR_EVT_CLR);
	assign wr_en   = psel & penable & pwrite;
	assign rd_en   = psel & ~penable & ~pwrite;
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~addr_ok;
	assign prdata  = prdata_q;

	// Configuration writes, including the socket mode.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q   <= PCS_CTRL_RESET;
			pullup_q <= '0;
			evt_en_q <= '0;
		end else if (wr_en) begin
			unique case (paddr)
				PCS_ADDR_CTRL:   ctrl_q   <= pwdata;
				PCS_ADDR_PULLUP: pullup_q <= pwdata[3:0];
				PCS_ADDR_EVT_EN: evt_en_q <= pwdata[PCS_EVT_N-1:0];
				default: ;
			endcase
		end
	end

	// Read data is registered in the setup phase so it stands for the whole access.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= PCS_ZERO;
		end else if (rd_en) begin
			unique case (paddr)
				PCS_ADDR_CTRL:   prdata_q <= ctrl_q;
				PCS_ADDR_PULLUP: prdata_q <= {28'h000_0000, pullup_q};
				PCS_ADDR_STATUS: prdata_q <= {24'h00_0000, card_vsense, card_present,
					ring_indicate_in, bat_warn, bat_dead, drive_activity_in,
					binary_speaker_in};
				PCS_ADDR_EVT:    prdata_q <= {28'h000_0000, evt_q};
				PCS_ADDR_EVT_EN: prdata_q <= {28'h000_0000, evt_en_q};
				default:         prdata_q <= PCS_ZERO;
			endcase
		end
	end

	// Card enables: accesses assert low; 8-bit access uses the even enable only.
	always_comb begin
		ce_odd_n_out  = 1'b1;
		ce_even_n_out = 1'b1;
		ce_odd_n_oe   = 1'b1;
		ce_even_n_oe  = 1'b1;
		unique case (mode)
			PCS_MODE_CB: begin
				ce_odd_n_out  = cb_ad10_out;
				ce_odd_n_oe   = cb_ad10_oe;
				ce_even_n_out = cb_cbe0_out;
				ce_even_n_oe  = cb_cbe0_oe;
			end
			default: begin
				if (acc.req && (ctrl_q[PCS_CTRL_BYTE8] || !acc.wide)) begin
					ce_even_n_out = 1'b0;
				end else if (acc.req) begin
					ce_even_n_out = ~acc.lo_en;
					ce_odd_n_out  = ~acc.hi_en;
				end
			end
		endcase
	end

	// Reset pin drives only when it cannot glitch a half-powered card.
	assign drive_ok = card_present & ctrl_q[PCS_CTRL_PWR] & ctrl_q[PCS_CTRL_IFEN];
	assign card_reset_oe = drive_ok;
	always_comb begin
		if (mode == PCS_MODE_CB) begin
			card_reset_out = ~ctrl_q[PCS_CTRL_RST];
		end else begin
			card_reset_out = ctrl_q[PCS_CTRL_RST];
		end
	end

	// Battery, audio, activity and ring pins by mode.
	assign bat_warn          = (mode == PCS_MODE_MEM) & pins.bvd2;
	assign bat_dead          = (mode == PCS_MODE_MEM) & pins.bvd1;
	assign binary_speaker_in = (mode == PCS_MODE_IO) & (aux == PCS_AUX_SPEAKER) & ~pins.bvd2;
	assign drive_activity_in = (mode == PCS_MODE_IO) & (aux == PCS_AUX_ACTIVITY) & ~pins.bvd2;
	assign cb_audio_in       = (mode == PCS_MODE_CB) & pins.bvd2;
	assign ring_indicate_in  = (mode == PCS_MODE_IO) & ctrl_q[PCS_CTRL_RING] & ~pins.bvd1;

	// Presence and voltage class.
	assign card_present = ~pins.cd1_n & ~pins.cd2_n;
	assign card_vsense  = {pins.vs2, pins.vs1};

	assign vs1_pullup_en = pullup_q[PCS_PU_DATA_LO] & pullup_q[PCS_PU_CD_LO];
	assign vs2_pullup_en = pullup_q[PCS_PU_DATA_LO + 1] & pullup_q[PCS_PU_CD_LO + 1];

	// Event sources are active-low levels; a falling edge is one event.
	assign evt_src[PCS_EVT_STSCHG] = ~((mode == PCS_MODE_IO) & ~ctrl_q[PCS_CTRL_RING] &
		~pins.bvd1);
	assign evt_src[PCS_EVT_RING]   = ~ring_indicate_in;
	assign evt_src[PCS_EVT_CD]     = ~card_present;
	assign evt_src[PCS_EVT_CBSTS]  = ~((mode == PCS_MODE_CB) & ~pins.bvd1);

	pcs_edge u_edge (
		.pclk    (pclk),
		.presetn (presetn),
		.lvl     (evt_src),
		.fall    (evt_fall)
	);

	// Sticky events; a new event in the clearing cycle survives the clear.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			evt_q <= '0;
		end else begin
			evt_q <= (evt_q & ~((wr_en && paddr == PCS_ADDR_EVT_CLR) ?
				pwdata[PCS_EVT_N-1:0] : '0)) | evt_fall;
		end
	end

	assign irq = |(evt_q & evt_en_q);

	a_ce_byte8: assert property (@(posedge pclk) disable iff (!presetn)
		(mode != PCS_MODE_CB && acc.req && ctrl_q[PCS_CTRL_BYTE8]) |->
		(!ce_even_n_out && ce_odd_n_out))
		else $error("8-bit access drove odd enable");
	a_ce_word: assert property (@(posedge pclk) disable iff (!presetn)
		(mode != PCS_MODE_CB && acc.req && acc.wide && !ctrl_q[PCS_CTRL_BYTE8]) |->
		(ce_even_n_out == !acc.lo_en && ce_odd_n_out == !acc.hi_en))
		else $error("word access enables wrong");
	a_ce_cardbus: assert property (@(posedge pclk) disable iff (!presetn)
		(mode == PCS_MODE_CB) |-> (ce_odd_n_out == cb_ad10_out && ce_even_n_out == cb_cbe0_out))
		else $error("cardbus enable reuse wrong");
	a_rst_float: assert property (@(posedge pclk) disable iff (!presetn)
		card_reset_oe |-> (card_present && ctrl_q[PCS_CTRL_PWR] && ctrl_q[PCS_CTRL_IFEN]))
		else $error("reset driven while unsafe");
	a_rst_polarity: assert property (@(posedge pclk) disable iff (!presetn)
		(card_reset_oe && $stable(mode)) |->
		(card_reset_out == ((mode == PCS_MODE_CB) ^ ctrl_q[PCS_CTRL_RST])))
		else $error("reset polarity wrong");
	a_pullup_joint: assert property (@(posedge pclk) disable iff (!presetn)
		vs1_pullup_en |-> (pullup_q[PCS_PU_DATA_LO] && pullup_q[PCS_PU_CD_LO]))
		else $error("pull-up without both bits");
	a_ring_gate: assert property (@(posedge pclk) disable iff (!presetn)
		ring_indicate_in |-> (ctrl_q[PCS_CTRL_RING] && mode == PCS_MODE_IO))
		else $error("ring without enable");
	a_evt_sticky: assert property (@(posedge pclk) disable iff (!presetn)
		(evt_fall[PCS_EVT_STSCHG]) |=> evt_q[PCS_EVT_STSCHG])
		else $error("status change lost");
	a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
		(evt_q == '0) |-> !irq)
		else $error("irq without event");

	a_ce_idle: assert property (@(posedge pclk) disable iff (!presetn)
		(mode != PCS_MODE_CB && !acc.req) |-> (ce_even_n_out && ce_odd_n_out))
		else $error("card enable active while idle");
	a_ce_drive: assert property (@(posedge pclk) disable iff (!presetn)
		(mode != PCS_MODE_CB) |-> (ce_even_n_oe && ce_odd_n_oe))
		else $error("card enable not driven");
	a_ce_narrow: assert property (@(posedge pclk) disable iff (!presetn)
		(mode != PCS_MODE_CB && acc.req && !acc.wide) |-> (!ce_even_n_out && ce_odd_n_out))
		else $error("narrow access enables wrong");
	a_ce_odd_only: assert property (@(posedge pclk) disable iff (!presetn)
		(mode != PCS_MODE_CB && !ce_odd_n_out) |-> (acc.req && acc.wide && !ctrl_q[PCS_CTRL_BYTE8]))
		else $error("odd enable outside word access");
	a_ce_cb_oe: assert property (@(posedge pclk) disable iff (!presetn)
		(mode == PCS_MODE_CB) |-> (ce_odd_n_oe == cb_ad10_oe && ce_even_n_oe == cb_cbe0_oe))
		else $error("cardbus enable direction wrong");

	a_rst_drive: assert property (@(posedge pclk) disable iff (!presetn)
		(card_present && ctrl_q[PCS_CTRL_PWR] && ctrl_q[PCS_CTRL_IFEN]) |-> card_reset_oe)
		else $error("reset pin not driven when safe");
	a_rst_absent: assert property (@(posedge pclk) disable iff (!presetn)
		!card_present |-> !card_reset_oe)
		else $error("reset driven into empty socket");
	a_rst_unpowered: assert property (@(posedge pclk) disable iff (!presetn)
		!ctrl_q[PCS_CTRL_PWR] |-> !card_reset_oe)
		else $error("reset driven without power");
	a_rst_16bit: assert property (@(posedge pclk) disable iff (!presetn)
		(mode != PCS_MODE_CB) |-> (card_reset_out == ctrl_q[PCS_CTRL_RST]))
		else $error("16-bit reset level wrong");
	a_rst_cb: assert property (@(posedge pclk) disable iff (!presetn)
		(mode == PCS_MODE_CB) |-> (card_reset_out == !ctrl_q[PCS_CTRL_RST]))
		else $error("cardbus reset level wrong");
	a_rst_follow: assert property (@(posedge pclk) disable iff (!presetn)
		(mode != PCS_MODE_CB && $stable(mode) && $rose(ctrl_q[PCS_CTRL_RST])) |-> card_reset_out)
		else $error("reset request not applied");

	a_warn_mem: assert property (@(posedge pclk) disable iff (!presetn)
		(mode == PCS_MODE_MEM) |-> (bat_warn == pins.bvd2))
		else $error("battery warning wrong");
	a_warn_off: assert property (@(posedge pclk) disable iff (!presetn)
		(mode != PCS_MODE_MEM) |-> !bat_warn)
		else $error("battery warning outside memory mode");
	a_speaker_io: assert property (@(posedge pclk) disable iff (!presetn)
		(mode == PCS_MODE_IO && aux == PCS_AUX_SPEAKER) |-> (binary_speaker_in == !pins.bvd2))
		else $error("speaker input wrong");
	a_speaker_off: assert property (@(posedge pclk) disable iff (!presetn)
		binary_speaker_in |-> (mode == PCS_MODE_IO && aux == PCS_AUX_SPEAKER))
		else $error("speaker input when not selected");
	a_activity_io: assert property (@(posedge pclk) disable iff (!presetn)
		(mode == PCS_MODE_IO && aux == PCS_AUX_ACTIVITY) |-> (drive_activity_in == !pins.bvd2))
		else $error("drive activity wrong");
	a_activity_off: assert property (@(posedge pclk) disable iff (!presetn)
		drive_activity_in |-> (mode == PCS_MODE_IO && aux == PCS_AUX_ACTIVITY))
		else $error("drive activity when not selected");
	a_audio_cb: assert property (@(posedge pclk) disable iff (!presetn)
		(mode == PCS_MODE_CB) |-> (cb_audio_in == pins.bvd2))
		else $error("cardbus audio wrong");
	a_audio_off: assert property (@(posedge pclk) disable iff (!presetn)
		(mode != PCS_MODE_CB) |-> !cb_audio_in)
		else $error("cardbus audio outside cardbus mode");
	a_dead_mem: assert property (@(posedge pclk) disable iff (!presetn)
		(mode == PCS_MODE_MEM) |-> (bat_dead == pins.bvd1))
		else $error("battery dead wrong");
	a_dead_off: assert property (@(posedge pclk) disable iff (!presetn)
		(mode != PCS_MODE_MEM) |-> !bat_dead)
		else $error("battery dead outside memory mode");
	a_ring_io: assert property (@(posedge pclk) disable iff (!presetn)
		(mode == PCS_MODE_IO && ctrl_q[PCS_CTRL_RING]) |-> (ring_indicate_in == !pins.bvd1))
		else $error("ring indicate wrong");

	a_stschg_src: assert property (@(posedge pclk) disable iff (!presetn)
		(mode == PCS_MODE_IO && !ctrl_q[PCS_CTRL_RING] && !pins.bvd1) |-> !evt_src[PCS_EVT_STSCHG])
		else $error("status change source idle");
	a_stschg_mute: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl_q[PCS_CTRL_RING] |-> evt_src[PCS_EVT_STSCHG])
		else $error("status change while ring selected");
	a_cbsts_src: assert property (@(posedge pclk) disable iff (!presetn)
		(mode == PCS_MODE_CB && !pins.bvd1) |-> !evt_src[PCS_EVT_CBSTS])
		else $error("cardbus status source idle");
	a_cbsts_mode: assert property (@(posedge pclk) disable iff (!presetn)
		(mode != PCS_MODE_CB) |-> evt_src[PCS_EVT_CBSTS])
		else $error("cardbus status outside cardbus mode");
	a_evt_clear: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_en && paddr == PCS_ADDR_EVT_CLR && pwdata[PCS_EVT_STSCHG] &&
		!evt_fall[PCS_EVT_STSCHG]) |=> !evt_q[PCS_EVT_STSCHG])
		else $error("status change not cleared");
	a_evt_hold: assert property (@(posedge pclk) disable iff (!presetn)
		(evt_q[PCS_EVT_STSCHG] && !(wr_en && paddr == PCS_ADDR_EVT_CLR)) |=>
		evt_q[PCS_EVT_STSCHG])
		else $error("status change dropped");
	a_ring_sticky: assert property (@(posedge pclk) disable iff (!presetn)
		evt_fall[PCS_EVT_RING] |=> evt_q[PCS_EVT_RING])
		else $error("ring event lost");
	a_irq_on: assert property (@(posedge pclk) disable iff (!presetn)
		(|(evt_q & evt_en_q)) |-> irq)
		else $error("enabled event without irq");

	a_vsense_pair: assert property (@(posedge pclk) disable iff (!presetn)
		card_vsense == {pins.vs2, pins.vs1})
		else $error("voltage sense pair wrong");
	a_pullup_two: assert property (@(posedge pclk) disable iff (!presetn)
		vs2_pullup_en |-> (pullup_q[PCS_PU_DATA_LO + 1] && pullup_q[PCS_PU_CD_LO + 1]))
		else $error("second pull-up without both bits");
	a_pullup_on: assert property (@(posedge pclk) disable iff (!presetn)
		(pullup_q[PCS_PU_DATA_LO] && pullup_q[PCS_PU_CD_LO]) |-> vs1_pullup_en)
		else $error("pull-up missing with both bits");
	a_present: assert property (@(posedge pclk) disable iff (!presetn)
		card_present |-> (!pins.cd1_n && !pins.cd2_n))
		else $error("presence without both detects");
	a_absent: assert property (@(posedge pclk) disable iff (!presetn)
		(pins.cd1_n || pins.cd2_n) |-> !card_present)
		else $error("presence with a detect released");

	a_ctrl_write: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_en && paddr == PCS_ADDR_CTRL) |=> (ctrl_q == $past(pwdata)))
		else $error("control write lost");
	a_bus_ready: assert property (@(posedge pclk) disable iff (!presetn)
		psel |-> pready)
		else $error("bus not ready");
	a_bus_error: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && penable && !addr_ok) |-> pslverr)
		else $error("unmapped access without error");
	a_read_ctrl: assert property (@(posedge pclk) disable iff (!presetn)
		(rd_en && paddr == PCS_ADDR_CTRL) |=> (prdata == $past(ctrl_q)))
		else $error("control read data wrong");

endmodule

// file: tb/pcs_card.sv
`timescale 1ns/1ps
// Card in the socket; with no card every status line rests at its pull-up.
module pcs_card
	import pcs_pkg::*;
(
	input  wire logic       seated,
	input  wire logic       bvd1,
	input  wire logic       bvd2,
	input  wire logic [1:0] vs,
	output pcs_pins_t       pins
);
	assign pins = seated ? {bvd1, bvd2, 2'h0, vs} : 6'h3F;
endmodule

// file: tb/testbench.sv
`timescale 1ns/1ps
module testbench
	import pcs_pkg::*;
;
	logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic        seated = 1'h1, bvd1 = 1'h1, bvd2 = 1'h1, err;
	logic        cb_ad10_out = 1'h0, cb_ad10_oe = 1'h0, cb_cbe0_out = 1'h0, cb_cbe0_oe = 1'h0;
	logic [1:0]  vs = 2'h0, card_vsense;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, rd, prdata;
	logic        pready, pslverr, ce_odd_n_out, ce_odd_n_oe, ce_even_n_out, ce_even_n_oe;
	logic        card_reset_out, card_reset_oe, vs1_pullup_en, vs2_pullup_en, irq;
	logic        bat_warn, bat_dead, binary_speaker_in, drive_activity_in, cb_audio_in;
	logic        ring_indicate_in, card_present;
	pcs_acc_t    acc = 5'h00;
	pcs_pins_t   pins;
	int          n_errors = 0, n_checks = 0;

	always #2.5 pclk = ~pclk;

	pcs_card card_u (.seated, .bvd1, .bvd2, .vs, .pins);
	pcs_socket dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .acc, .cb_ad10_out, .cb_ad10_oe, .cb_cbe0_out, .cb_cbe0_oe, .pins,
		.ce_odd_n_out, .ce_odd_n_oe, .ce_even_n_out, .ce_even_n_oe, .card_reset_out,
		.card_reset_oe, .vs1_pullup_en, .vs2_pullup_en, .bat_warn, .bat_dead,
		.binary_speaker_in, .drive_activity_in, .cb_audio_in, .ring_indicate_in,
		.card_present, .card_vsense, .irq);

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Starts just after a rising edge and ends on one, so psel never gets two drives at once.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'h1 && n < 20);
		if (pready !== 1'h1) begin
			n_errors++;
			$display("[FAIL] pready expected 1 seen %b", pready);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		apb(1'h1, a, d);
		@(negedge pclk);
	endtask

	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
		@(posedge pclk);
		apb(1'h0, a, PCS_ZERO);
		chk(nm, e, rd);
		@(negedge pclk);
	endtask

	task automatic t_regs;
		rdc("ctrl", PCS_ADDR_CTRL, PCS_CTRL_RESET);
		rdc("unmapped", 8'h18, PCS_ZERO);
		chk("pslverr", 1'h1, err);
		wr(PCS_ADDR_CTRL, 32'h0000_0155);
		rdc("ctrl_back", PCS_ADDR_CTRL, 32'h0000_0155);
	endtask

	task automatic t_ce;
		wr(PCS_ADDR_CTRL, PCS_ZERO);
		@(posedge pclk);
		acc <= 5'h1E;
		@(negedge pclk);
		chk("ce_word", 2'h0, {ce_odd_n_out, ce_even_n_out});
		@(posedge pclk);
		acc <= 5'h1A;
		@(negedge pclk);
		chk("ce_odd", 2'h1, {ce_odd_n_out, ce_even_n_out});
		wr(PCS_ADDR_CTRL, 32'h0000_0100);
		@(posedge pclk);
		acc <= 5'h17;
		@(negedge pclk);
		chk("ce_byte8", 2'h2, {ce_odd_n_out, ce_even_n_out});
		@(posedge pclk);
		acc <= 5'h00;
		@(negedge pclk);
		chk("ce_idle", 2'h3, {ce_odd_n_out, ce_even_n_out});
		wr(PCS_ADDR_CTRL, 32'h0000_0002);
		for (int i = 0; i < 2; i++) begin
			@(posedge pclk);
			{cb_ad10_out, cb_ad10_oe, cb_cbe0_out, cb_cbe0_oe} <= i ? 4'h6 : 4'hB;
			@(negedge pclk);
			chk("ce_cb", i ? 4'h6 : 4'hB,
				{ce_odd_n_out, ce_odd_n_oe, ce_even_n_out, ce_even_n_oe});
		end
	endtask

	task automatic t_rst;
		logic [31:0] cv[7] = '{32'h70, 32'h30, 32'h60, 32'h50, 32'h72, 32'h32, 32'h32};
		logic [1:0]  ev[7] = '{2'h3, 2'h2, 2'h0, 2'h0, 2'h2, 2'h3, 2'h0};
		for (int i = 0; i < 7; i++) begin
			@(posedge pclk);
			seated <= (i < 6);
			wr(PCS_ADDR_CTRL, cv[i]);
			chk("reset_pin", ev[i], {card_reset_oe, card_reset_oe & card_reset_out});
		end
		@(posedge pclk);
		seated <= 1'h1;
	endtask

	task automatic t_mux;
		logic [31:0] cv[6] = '{32'h000, 32'h000, 32'h005, 32'h009, 32'h002, 32'h081};
		logic [1:0]  bv[6] = '{2'h2, 2'h1, 2'h2, 2'h2, 2'h3, 2'h1};
		logic [5:0]  ev[6] = '{6'h10, 6'h20, 6'h08, 6'h04, 6'h02, 6'h01};
		for (int i = 0; i < 6; i++) begin
			@(posedge pclk);
			{bvd1, bvd2} <= bv[i];
			wr(PCS_ADDR_CTRL, cv[i]);
			chk("status_mux", ev[i], {bat_warn, bat_dead, binary_speaker_in, drive_activity_in,
				cb_audio_in, ring_indicate_in});
		end
	endtask

	task automatic t_vs;
		logic [3:0] pv[4] = '{4'h5, 4'h9, 4'hF, 4'h6};
		logic [1:0] ev[4] = '{2'h1, 2'h0, 2'h3, 2'h0};
		@(posedge pclk);
		vs <= 2'h1;
		@(negedge pclk);
		chk("vsense", 2'h2, card_vsense);
		chk("present", 1'h1, card_present);
		rdc("status", PCS_ADDR_STATUS, 32'h0000_00B0);
		for (int i = 0; i < 4; i++) begin
			wr(PCS_ADDR_PULLUP, {28'h000_0000, pv[i]});
			chk("pullups", ev[i], {vs2_pullup_en, vs1_pullup_en});
		end
		@(posedge pclk);
		seated <= 1'h0;
		@(negedge pclk);
		chk("absent", 1'h0, card_present);
		@(posedge pclk);
		seated <= 1'h1;
	endtask

	task automatic t_evt;
		@(posedge pclk);
		bvd1 <= 1'h1;
		wr(PCS_ADDR_CTRL, 32'h0000_0001);
		wr(PCS_ADDR_EVT_CLR, 32'h0000_000F);
		wr(PCS_ADDR_EVT_EN, 32'h0000_0001);
		chk("irq_quiet", 1'h0, irq);
		@(posedge pclk);
		bvd1 <= 1'h0;
		repeat (3) @(negedge pclk);
		rdc("evt_set", PCS_ADDR_EVT, 32'h0000_0001);
		chk("irq_on", 1'h1, irq);
		wr(PCS_ADDR_EVT_EN, PCS_ZERO);
		chk("irq_masked", 1'h0, irq);
		wr(PCS_ADDR_EVT_EN, 32'h0000_0001);
		wr(PCS_ADDR_EVT_CLR, 32'h0000_0001);
		chk("irq_cleared", 1'h0, irq);
		rdc("evt_clear", PCS_ADDR_EVT, PCS_ZERO);
		@(posedge pclk);
		bvd1 <= 1'h1;
		wr(PCS_ADDR_CTRL, 32'h0000_0002);
		wr(PCS_ADDR_EVT_CLR, 32'h0000_000F);
		@(posedge pclk);
		bvd1 <= 1'h0;
		repeat (2) @(negedge pclk);
		rdc("evt_cb", PCS_ADDR_EVT, 32'h0000_0008);
	endtask

	task automatic stop_test;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'h1;
		@(negedge pclk);
		t_regs();
		t_ce();
		t_rst();
		t_mux();
		t_vs();
		t_evt();
		stop_test();
	end

	// A hang inside a wait loop ends the run here instead of running forever.
	initial begin
		#20000;
		n_errors++;
		stop_test();
	end
endmodule
